// ===== mbp_consts.svh
// constants for the serial master poller: timing counts and protocol figures
// assumes a 100 MHz clk; included by the poller by bare name
`ifndef MBP_CONSTS_SVH
`define MBP_CONSTS_SVH
`define MBP_ADDR_BCAST 8'h00
`define MBP_ADDR_MAX 8'hf7
`define MBP_FAIL_LIMIT 2'h3
`define MBP_DIAG_LEN 8'h03
`define MBP_DIAG_PERIOD_US 1000
`define MBP_CLK_MHZ 100
`define MBP_DIAG_CYCLES (`MBP_DIAG_PERIOD_US * `MBP_CLK_MHZ)
`define MBP_REC_DEPTH 16
`endif

// ===== mbp_pkg.sv
// types for the serial master poller
// no assumptions beyond the constants header
package mbp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] func;
    logic [15:0] data;
  } mbp_req_t;

  typedef struct packed {
    logic [7:0] len;
    logic [7:0] page;
    logic [7:0] module_no;
  } mbp_diag_t;

  typedef enum logic [2:0] {
    MBP_IDLE = 3'b000,
    MBP_SEND = 3'b001,
    MBP_WAIT = 3'b010,
    MBP_DIAG = 3'b011,
    MBP_DWAIT = 3'b100,
    MBP_LEARN = 3'b101
  } mbp_state_t;
endpackage

// ===== mbp_timer.sv
// down counter used for the response timeout and the diagnose period
// load takes priority over counting; expired pulses one cycle at zero crossing
`timescale 1ns/1ps
module mbp_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic stop,
  input wire logic [31:0] count,
  output logic expired
);
  logic [31:0] cnt_r;
  logic run_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= (count == 32'h0) ? 32'h1 : count;
      run_r <= 1'b1;
    end else if (stop) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 32'h1;
      if (cnt_r == 32'h1) begin
        run_r <= 1'b0;
      end
    end
  end

  assign expired = run_r && !load && !stop && (cnt_r == 32'h1);
endmodule

// ===== mbp_poller.sv
// serial master request/response sequencer with diagnostic mode and learning
// assumes a framer outside: requests leave on req_*, replies arrive as pulses
`timescale 1ns/1ps
`include "mbp_consts.svh"
module mbp_poller
  import mbp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic master_mode,
  input wire logic learn_en,
  input wire logic [31:0] timeout_cycles,
  input wire mbp_req_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_page,
  input wire logic [7:0] cmd_module,
  output mbp_req_t req_out,
  output logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_ok,
  input wire logic rsp_exc,
  input wire mbp_req_t snoop_req,
  input wire logic snoop_valid,
  output mbp_diag_t diag_out,
  output logic diag_valid,
  output logic diag_mode,
  output logic timeout_pulse,
  output logic cmd_reject,
  output logic learning,
  output logic [4:0] learn_count,
  output mbp_req_t learn_rd_data,
  input wire logic [3:0] learn_rd_idx
);
  logic rs1_r;
  logic rst_n;
  mbp_state_t state_r;
  mbp_req_t hold_r;
  logic [7:0] page_r;
  logic [7:0] mod_r;
  logic [1:0] fail_r;
  logic tmo_load;
  logic tmo_exp;
  logic per_load;
  logic per_exp;
  logic reply;
  logic addr_ok;
  logic learn_act;
  mbp_req_t rec_mem [`MBP_REC_DEPTH];
  logic [4:0] rec_cnt_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  // reply input is only meaningful when we wait on one; stray ones are dropped
  assign reply = rsp_ok || rsp_exc;
  assign addr_ok = (cmd.addr <= `MBP_ADDR_MAX);
  assign learn_act = learn_en && master_mode;
  assign learning = (state_r == MBP_LEARN);
  assign cmd_ready = (state_r == MBP_IDLE) && !learn_act;
  assign cmd_reject = cmd_valid && cmd_ready && !addr_ok;
  assign tmo_load = (state_r == MBP_SEND || state_r == MBP_DIAG) && req_ready
                    && hold_r.addr != `MBP_ADDR_BCAST;
  assign per_load = (state_r == MBP_DWAIT) && (tmo_exp || rsp_exc);
  assign diag_mode = (state_r == MBP_DIAG) || (state_r == MBP_DWAIT);
  assign timeout_pulse = tmo_exp;

  mbp_timer u_tmo (
    .clk(clk),
    .rst_n(rst_n),
    .load(tmo_load),
    .stop((state_r == MBP_WAIT || state_r == MBP_DWAIT) && reply),
    .count(timeout_cycles),
    .expired(tmo_exp)
  );

  // a period left running after an exit must not cut short a later diag session
  mbp_timer u_per (
    .clk(clk),
    .rst_n(rst_n),
    .load(per_load),
    .stop(state_r != MBP_DWAIT),
    .count(32'(`MBP_DIAG_CYCLES)),
    .expired(per_exp)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MBP_IDLE;
    end else begin
      case (state_r)
        MBP_IDLE: begin
          if (learn_act) begin
            state_r <= MBP_LEARN;
          end else if (cmd_valid && addr_ok && master_mode) begin
            state_r <= MBP_SEND;
          end
        end
        MBP_SEND: begin
          if (req_ready) begin
            // broadcast gets no reply, so the line is free at once
            state_r <= (hold_r.addr == `MBP_ADDR_BCAST) ? MBP_IDLE : MBP_WAIT;
          end
        end
        MBP_WAIT: begin
          if (reply) begin
            state_r <= MBP_IDLE;
          end else if (tmo_exp) begin
            state_r <= (fail_r == `MBP_FAIL_LIMIT - 2'h1) ? MBP_DIAG : MBP_IDLE;
          end
        end
        MBP_DIAG: begin
          if (req_ready) begin
            state_r <= (hold_r.addr == `MBP_ADDR_BCAST) ? MBP_IDLE : MBP_DWAIT;
          end
        end
        MBP_DWAIT: begin
          if (rsp_ok) begin
            state_r <= MBP_IDLE;
          end else if (per_exp) begin
            state_r <= MBP_DIAG;
          end
        end
        MBP_LEARN: begin
          if (!learn_act) begin
            state_r <= MBP_IDLE;
          end
        end
        default: state_r <= MBP_IDLE;
      endcase
    end
  end

  // request latch: the target address always travels with the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
      page_r <= 8'h00;
      mod_r <= 8'h00;
    end else if (state_r == MBP_IDLE && cmd_valid && addr_ok && master_mode && !learn_act) begin
      hold_r <= cmd;
      page_r <= cmd_page;
      mod_r <= cmd_module;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_r <= 2'h0;
    end else if (rsp_ok && (state_r == MBP_WAIT || state_r == MBP_DWAIT)) begin
      fail_r <= 2'h0;
    end else if (state_r == MBP_WAIT && tmo_exp && fail_r != `MBP_FAIL_LIMIT) begin
      fail_r <= fail_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_out <= '0;
      req_valid <= 1'b0;
    end else if ((state_r == MBP_SEND || state_r == MBP_DIAG) && req_ready) begin
      req_valid <= 1'b0;
    end else if (state_r == MBP_SEND || state_r == MBP_DIAG) begin
      req_out <= hold_r;
      req_valid <= 1'b1;
    end else begin
      req_valid <= 1'b0;
    end
  end

  // one diagnose packet per poll attempt in diagnostic mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_out <= '0;
      diag_valid <= 1'b0;
    end else begin
      diag_valid <= (state_r == MBP_DIAG) && req_ready;
      diag_out <= '{len: `MBP_DIAG_LEN, page: page_r, module_no: mod_r};
    end
  end

  // learning table: recorded requests; extras beyond depth are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt_r <= 5'h0;
    end else if (state_r == MBP_IDLE && learn_act) begin
      rec_cnt_r <= 5'h0;
    end else if (learning && snoop_valid && rec_cnt_r != 5'(`MBP_REC_DEPTH)) begin
      rec_cnt_r <= rec_cnt_r + 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (learning && snoop_valid && rec_cnt_r != 5'(`MBP_REC_DEPTH)) begin
      rec_mem[rec_cnt_r[3:0]] <= snoop_req;
    end
  end

  assign learn_count = rec_cnt_r;
  assign learn_rd_data = rec_mem[learn_rd_idx];

  a_bcast_nowait: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_SEND && req_ready && hold_r.addr == 8'h00 |=> state_r == MBP_IDLE)
    else $error("broadcast waited for reply");
  a_one_outst: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_WAIT |-> !req_valid)
    else $error("new request accepted while waiting");
  a_wait_reply: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_WAIT && !reply && !tmo_exp |=> state_r == MBP_WAIT)
    else $error("left wait without reply or timeout");
  a_tmo_free: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_WAIT && tmo_exp && !reply |=> state_r != MBP_WAIT)
    else $error("timeout did not free master");
  a_diag_entry: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_WAIT && tmo_exp && !reply && fail_r == 2'h2 |=> diag_mode)
    else $error("third failure did not enter diag");
  a_diag_exit: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_DWAIT && rsp_ok |=> !diag_mode && fail_r == 2'h0)
    else $error("correct reply did not leave diag");
  a_diag_len: assert property (@(posedge clk) disable iff (!rst_n)
    diag_valid |-> diag_out.len == 8'h03 && $past(state_r) == MBP_DIAG)
    else $error("bad diagnose packet");
  a_req_addr: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid |-> req_out.addr <= 8'hf7 && req_out == hold_r)
    else $error("request address bad");
  a_learn_mstr: assert property (@(posedge clk) disable iff (!rst_n)
    learning |-> $past(master_mode) || master_mode)
    else $error("learning outside master mode");
  a_fail_clr: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == MBP_WAIT && rsp_ok |=> fail_r == 2'h0)
    else $error("counter not cleared by reply");
endmodule

// ===== mbp_slave_model.sv
// far-side model: framer accept plus one slave reply after a fixed delay
// assumes the poller request port; mode 0 normal, 1 exception, 2 silent
`timescale 1ns/1ps
module mbp_slave_model
  import mbp_pkg::*;
(
  input wire logic clk,
  input wire mbp_req_t req_out,
  input wire logic req_valid,
  input wire logic [1:0] mode,
  output logic req_ready,
  output logic rsp_ok,
  output logic rsp_exc
);
  logic [7:0] addr_seen;
  initial begin
    req_ready = 1'b0;
    rsp_ok = 1'b0;
    rsp_exc = 1'b0;
  end
  always begin
    @(posedge clk);
    if (req_valid === 1'b1) begin
      addr_seen = req_out.addr;
      req_ready <= 1'b1;
      @(posedge clk);
      req_ready <= 1'b0;
      // answers only a unicast request, one at a time
      if (addr_seen != 8'h00 && mode != 2'h2) begin
        repeat (10) @(posedge clk);
        rsp_ok <= (mode == 2'h0);
        rsp_exc <= (mode == 2'h1);
        @(posedge clk);
        rsp_ok <= 1'b0;
        rsp_exc <= 1'b0;
      end
    end
  end
endmodule

// ===== mbp_poller_bench.sv
// self-checking bench for the serial master poller
// assumes the slave model on the line side; the diagnose period is left long
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module mbp_poller_bench
  import mbp_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, master_mode = 1'b1, learn_en = 1'b0, cmd_valid = 1'b0;
  logic snoop_valid = 1'b0, cmd_ready, req_valid, req_ready, rsp_ok, rsp_exc, diag_valid;
  logic diag_mode, timeout_pulse, cmd_reject, learning;
  logic [31:0] timeout_cycles = 32'd30;
  logic [7:0] cmd_page = 8'h01, cmd_module = 8'h03;
  logic [3:0] learn_rd_idx = 4'h0;
  logic [4:0] learn_count;
  logic [1:0] mode = 2'h0;
  mbp_req_t cmd = '0, snoop_req = '0, req_out, learn_rd_data;
  mbp_diag_t diag_out;
  int fail_count = 0, n_tests = 0, n;
  logic rej;
  always #5 clk = ~clk;
  mbp_poller u_mbp_poller (.clk(clk), .resetn(resetn), .master_mode(master_mode),
    .learn_en(learn_en), .timeout_cycles(timeout_cycles), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_page(cmd_page), .cmd_module(cmd_module), .req_out(req_out),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_ok(rsp_ok), .rsp_exc(rsp_exc),
    .snoop_req(snoop_req), .snoop_valid(snoop_valid), .diag_out(diag_out),
    .diag_valid(diag_valid), .diag_mode(diag_mode), .timeout_pulse(timeout_pulse),
    .cmd_reject(cmd_reject), .learning(learning), .learn_count(learn_count),
    .learn_rd_data(learn_rd_data), .learn_rd_idx(learn_rd_idx));
  mbp_slave_model u_mbp_slave_model (.clk(clk), .req_out(req_out), .req_valid(req_valid),
    .mode(mode), .req_ready(req_ready), .rsp_ok(rsp_ok), .rsp_exc(rsp_exc));
  function automatic logic pick(input int s);
    return s == 0 ? cmd_ready : s == 1 ? req_valid : s == 2 ? timeout_pulse :
      s == 3 ? diag_mode : diag_valid;
  endfunction
  // counts settled half-cycle samples until the chosen output is high
  task automatic wait_for(input int s, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pick(s) !== 1'b1 && n < lim);
  endtask
  task automatic issue(input logic [7:0] a);
    @(posedge clk);
    cmd <= '{a, 8'h03, 16'h0010};
    cmd_valid <= 1'b1;
    wait_for(0, 300);
    rej = cmd_reject;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic t_reserved();
    for (int a = 248; a < 256; a += 7) begin
      issue(8'(a));
      `CHK("reject", 1'b1, rej)
      wait_for(1, 5);
      `CHK("no_req", 5, n)
    end
  endtask
  task automatic t_unicast();
    issue(8'd247);
    `CHK("not_rej", 1'b0, rej)
    wait_for(1, 10);
    `CHK("addr", 8'd247, req_out.addr)
    repeat (5) @(negedge clk);
    `CHK("busy", 1'b0, cmd_ready)
    wait_for(0, 40);
    `CHK("freed", 1'b1, n < 20)
  endtask
  task automatic t_bcast();
    issue(8'h00);
    wait_for(1, 10);
    wait_for(0, 40);
    `CHK("bc_free", 1'b1, n < 6)
  endtask
  task automatic t_exc();
    mode <= 2'h1;
    issue(8'd1);
    wait_for(0, 40);
    `CHK("exc_ends", 1'b1, cmd_ready)
    `CHK("exc_early", 1'b1, n < 30)
  endtask
  task automatic t_learn();
    @(posedge clk);
    master_mode <= 1'b0;
    learn_en <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK("no_learn", 1'b0, learning)
    @(posedge clk);
    master_mode <= 1'b1;
    snoop_req <= '{8'd7, 8'h04, 16'h1234};
    repeat (3) @(posedge clk);
    snoop_valid <= 1'b1;
    @(posedge clk);
    snoop_valid <= 1'b0;
    @(negedge clk);
    `CHK("learning", 1'b1, learning)
    `CHK("lcount", 5'd1, learn_count)
    `CHK("ldata", snoop_req, learn_rd_data)
    @(posedge clk);
    learn_en <= 1'b0;
    wait_for(0, 20);
  endtask
  // one request with a chosen slave behaviour, then the diag state seen
  task automatic one(input logic [1:0] m, input logic [7:0] a, input logic d);
    mode <= m;
    issue(a);
    wait_for(1, 10);
    `CHK("tout_spacing", 1'b0, timeout_pulse)
    wait_for(m == 2'h2 ? 2 : 0, 60);
    if (m == 2'h2) `CHK("tout_time", 1'b1, n >= 30 && n < 36)
    repeat (2) @(negedge clk);
    `CHK("diag", d, diag_mode)
  endtask
  task automatic t_diag();
    one(2'h2, 8'd3, 1'b0);
    one(2'h2, 8'd3, 1'b0);
    one(2'h0, 8'd3, 1'b0);
    one(2'h2, 8'd3, 1'b0);
    one(2'h2, 8'd3, 1'b0);
    one(2'h2, 8'd3, 1'b1);
    mode <= 2'h0;
    wait_for(4, 10);
    `CHK("diag_pulse", 1'b1, diag_valid)
    `CHK("diag_pkt", 24'h030103, diag_out)
    wait_for(0, 30);
    `CHK("diag_exit", 1'b0, diag_mode)
    one(2'h2, 8'd3, 1'b0);
    one(2'h2, 8'd3, 1'b0);
    one(2'h2, 8'd3, 1'b1);
  endtask
  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reserved();
    t_unicast();
    t_bcast();
    t_exc();
    t_learn();
    t_diag();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
